//--- bmspi_pkg.sv
package bmspi_pkg;

	////////////////////////////////////////////////////////////////////
	// Two-wire targets, write form of the address byte
	localparam logic [7:0] TWI_SENSOR_ADDR = 8'h98;
	localparam logic [7:0] TWI_FILT1_ADDR = 8'hA0;
	localparam logic [7:0] TWI_FILT2_ADDR = 8'hA2;
	localparam logic [7:0] TWI_RD_BIT = 8'h01;
	localparam logic [1:0] TGT_SENSOR = 2'h0;
	localparam logic [1:0] TGT_FILT1 = 2'h1;
	localparam logic [1:0] TGT_FILT2 = 2'h2;

	// Sensor command bytes
	localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
	localparam logic [7:0] CMD_START_CONV = 8'hEE;
	localparam logic [7:0] CMD_STOP_CONV = 8'h22;
	localparam logic [7:0] CMD_ACCESS_MEM = 8'h17;
	localparam logic [7:0] CMD_ACCESS_CFG = 8'hAC;

	// Inventory layout, in bytes
	localparam int FRU_SIZE = 256;
	localparam int FRU_HDR_SIZE = 8;
	localparam int FRU_INT_SIZE = 48;
	localparam int FRU_BOARD_SIZE = 80;
	localparam int FRU_PROD_SIZE = 80;
	localparam logic [7:0] FRU_BOARD_OFS = 8'h38;
	localparam logic [7:0] FRU_FMT_VER = 8'h01;
	localparam logic [7:0] FRU_LANG_LATIN1 = 8'h00;
	localparam logic [7:0] FRU_BOARD_LEN = 8'h0A;
	localparam int FRU_LEN_UNIT_SH = 3;
	localparam logic [1:0] FRU_TL_ASCII = 2'h3;
	localparam logic [7:0] FRU_EOI = 8'hC1;
	localparam int FRU_TS_EPOCH_YEAR = 1996;

	////////////////////////////////////////////////////////////////////
	// Chain select codes on the four select lines
	localparam logic [3:0] SEL_CTRL = 4'h1;
	localparam logic [3:0] SEL_STAT = 4'h0;
	localparam logic [3:0] SEL_ADC = 4'h2;
	localparam logic [3:0] SEL_CONFL = 4'h3;
	localparam int SEL_IO_BIT = 3;
	localparam int SEL_BAD_BIT = 2;
	localparam int CHAIN_CTRL_BITS = 16;
	localparam int CHAIN_STAT_BITS = 32;
	localparam int CHAIN_CONFL_BITS = 11;
	localparam int CTRL_FORCE_EN_BIT = 15;

	////////////////////////////////////////////////////////////////////
	// Own register map, byte offsets
	localparam logic [7:0] REG_SPI_CMD = 8'h00;
	localparam logic [7:0] REG_SPI_TX = 8'h04;
	localparam logic [7:0] REG_SPI_RX = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_TWI_CMD = 8'h10;
	localparam logic [7:0] REG_TWI_WDATA = 8'h14;
	localparam logic [7:0] REG_TWI_RDATA = 8'h18;
	localparam logic [7:0] REG_FRU = 8'h1C;
	localparam logic [7:0] REG_FRU_AREA = 8'h20;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [3:0] RST_SEL = 4'h0;

	////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCLK_PERIOD_NS = 800;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int TWI_BIT_NS = 10000;
	localparam int TWI_QTR_CYC = TWI_BIT_NS / (4 * CLK_PERIOD_NS);

	typedef enum logic [1:0] {SP_IDLE, SP_HIGH, SP_LOW, SP_END} bmspi_sp_t;
	typedef enum logic [1:0] {TW_IDLE, TW_START, TW_BIT, TW_STOP} bmspi_tw_t;

	function automatic logic [5:0] tl_count(input logic [7:0] b);
		tl_count = b[5:0];
	endfunction : tl_count

	function automatic logic tl_is_ascii(input logic [7:0] b);
		tl_is_ascii = (b[7:6] == FRU_TL_ASCII);
	endfunction : tl_is_ascii

endpackage : bmspi_pkg

//--- bmspi_sync.sv
`timescale 1ns/1ps
module bmspi_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : bmspi_sync

//--- bmspi_twi.sv
`timescale 1ns/1ps
module bmspi_twi #(
	parameter int QTR = bmspi_pkg::TWI_QTR_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] addr,
	input wire logic [15:0] wbytes,
	input wire logic [1:0] nwr,
	input wire logic [1:0] nrd,
	input wire logic sda_in,
	input wire logic scl_in,
	output logic busy,
	output logic done,
	output logic nack,
	output logic [15:0] rdata,
	output logic rbyte_valid,
	output logic [7:0] rbyte,
	output logic scl_oe,
	output logic sda_oe
);
	bmspi_pkg::bmspi_tw_t st_q;
	logic [15:0] tick_q;
	logic [1:0] qtr_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] addr_q;
	logic [15:0] wb_q;
	logic [1:0] wl_q;
	logic [1:0] rl_q;
	logic rdseg_q;
	logic adrb_q;
	logic step;
	logic is_tx;

	// Clock stretching holds the high quarter until the line is high
	assign step = (tick_q >= 16'(QTR - 1)) && !(qtr_q == 2'h2 && !scl_in);
	assign is_tx = !rdseg_q || adrb_q;
	assign busy = (st_q != bmspi_pkg::TW_IDLE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_q <= '0;
		end else begin
			tick_q <= (st_q == bmspi_pkg::TW_IDLE || step) ? 16'h0000
				: tick_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= bmspi_pkg::TW_IDLE;
			qtr_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			addr_q <= 8'h00;
			wb_q <= 16'h0000;
			wl_q <= 2'h0;
			rl_q <= 2'h0;
			rdseg_q <= 1'b0;
			adrb_q <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
			rdata <= 16'h0000;
			rbyte_valid <= 1'b0;
			rbyte <= 8'h00;
		end else begin
			done <= 1'b0;
			rbyte_valid <= 1'b0;
			unique case (st_q)
			bmspi_pkg::TW_IDLE: begin
				if (start) begin
					st_q <= bmspi_pkg::TW_START;
					qtr_q <= 2'h0;
					addr_q <= addr;
					sh_q <= addr;
					wb_q <= wbytes;
					wl_q <= nwr;
					rl_q <= nrd;
					rdseg_q <= 1'b0;
					adrb_q <= 1'b1;
					nack <= 1'b0;
				end
			end
			bmspi_pkg::TW_START: begin
				if (step) begin
					qtr_q <= qtr_q + 2'h1;
					unique case (qtr_q)
					2'h0: sda_oe <= 1'b0;
					2'h1: scl_oe <= 1'b0;
					2'h2: sda_oe <= 1'b1;
					2'h3: begin
						scl_oe <= 1'b1;
						st_q <= bmspi_pkg::TW_BIT;
						bit_q <= 4'h0;
					end
					endcase
				end
			end
			bmspi_pkg::TW_BIT: begin
				if (step) begin
					qtr_q <= qtr_q + 2'h1;
					unique case (qtr_q)
					2'h0: begin
						if (bit_q != 4'h8) begin
							sda_oe <= is_tx ? !sh_q[7] : 1'b0;
						end else begin
							sda_oe <= is_tx ? 1'b0 : (rl_q > 2'h1);
						end
					end
					2'h1: scl_oe <= 1'b0;
					2'h2: begin
						if (bit_q != 4'h8) begin
							sh_q <= {sh_q[6:0], sda_in};
						end else if (is_tx && sda_in) begin
							nack <= 1'b1;
						end
					end
					2'h3: begin
						scl_oe <= 1'b1;
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h8) begin
							bit_q <= 4'h0;
							adrb_q <= 1'b0;
							if (is_tx && nack) begin
								st_q <= bmspi_pkg::TW_STOP;
							end else if (rdseg_q && !adrb_q) begin
								rdata <= {rdata[7:0], sh_q};
								rbyte <= sh_q;
								rbyte_valid <= 1'b1;
								rl_q <= rl_q - 2'h1;
								if (rl_q == 2'h1) begin
									st_q <= bmspi_pkg::TW_STOP;
								end
							end else if (!rdseg_q && wl_q != 2'h0) begin
								sh_q <= wb_q[7:0];
								wb_q <= {8'h00, wb_q[15:8]};
								wl_q <= wl_q - 2'h1;
							end else if (!rdseg_q && rl_q != 2'h0) begin
								st_q <= bmspi_pkg::TW_START;
								sh_q <= addr_q | bmspi_pkg::TWI_RD_BIT;
								rdseg_q <= 1'b1;
								adrb_q <= 1'b1;
							end else if (!rdseg_q) begin
								st_q <= bmspi_pkg::TW_STOP;
							end
						end
					end
					endcase
				end
			end
			bmspi_pkg::TW_STOP: begin
				if (step) begin
					qtr_q <= qtr_q + 2'h1;
					unique case (qtr_q)
					2'h0: sda_oe <= 1'b1;
					2'h1: scl_oe <= 1'b0;
					2'h2: sda_oe <= 1'b0;
					2'h3: begin
						st_q <= bmspi_pkg::TW_IDLE;
						done <= 1'b1;
					end
					endcase
				end
			end
			endcase
		end
	end
endmodule : bmspi_twi

//--- bmspi_top.sv
`timescale 1ns/1ps
// Function
// - Carrier sensor sits at two-wire address 98h write, 99h read.
// - Filter one inventory memory at A0h/A1h, filter two at A2h/A3h.
// - Inventory memory: 256 bytes, header 8, internal 48, board 80, product 80.
// - Board area opens with version 01h then language 00h for Latin-1.
// - Board area length byte counts units of eight bytes.
// - Timestamp field counts minutes since the start of 1996.
// - Type/length byte: top bits mark ASCII, low bits give byte count.
// - Board field list ends with marker byte C1h.
// - Last board area byte is a mandatory checksum.
// - Sensor commands AAh read two bytes, EEh start, 22h stop.
// - Sensor command 17h reaches its EEPROM, ACh its config register.
// - Select codes 1,0,2,3 pick chains; top line high means other board.
module bmspi_top #(
	parameter int SCLK_HALF = bmspi_pkg::SCLK_HALF_CYC,
	parameter int TWI_QTR = bmspi_pkg::TWI_QTR_CYC
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic SPI_SCLK,
	output logic SPI_CS_N,
	output logic [3:0] SPI_SEL,
	output logic SPI_MOSI,
	input wire logic SPI_MISO,
	input wire logic TWI_SCL_I,
	output logic TWI_SCL_O,
	output logic TWI_SCL_OE,
	input wire logic TWI_SDA_I,
	output logic TWI_SDA_O,
	output logic TWI_SDA_OE
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic miso_s;
	logic sda_s;
	logic scl_s;

	bmspi_sync #(.W(3)) u_sync (
		.clk(REF_CLK),
		.rst(RST),
		.din({SPI_MISO, TWI_SDA_I, TWI_SCL_I}),
		.dout({miso_s, sda_s, scl_s})
	);

	////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait, read data registered in the address phase
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] spi_tx_q;
	logic [31:0] spi_rx_q;
	logic [15:0] twi_wd_q;
	logic [7:0] fru_sum_q;
	logic [7:0] fru_last_q;
	logic spi_done_q;
	logic twi_done_q;
	logic twi_nack_q;
	logic [5:0] spi_nbits_q;
	logic [1:0] twi_tgt_q;
	wire logic acc = HSEL && HTRANS[1] && HREADY;
	wire logic [7:0] a_ofs = HADDR[7:0];
	wire logic wr_cmd = wr_pend_q && wr_addr_q == bmspi_pkg::REG_SPI_CMD;
	wire logic wr_tx = wr_pend_q && wr_addr_q == bmspi_pkg::REG_SPI_TX;
	wire logic wr_st = wr_pend_q && wr_addr_q == bmspi_pkg::REG_STATUS;
	wire logic wr_tcmd = wr_pend_q && wr_addr_q == bmspi_pkg::REG_TWI_CMD;
	wire logic wr_twd = wr_pend_q && wr_addr_q == bmspi_pkg::REG_TWI_WDATA;
	wire logic wr_fru = wr_pend_q && wr_addr_q == bmspi_pkg::REG_FRU;
	wire logic spi_busy;
	wire logic twi_busy;
	wire logic [15:0] twi_rdata;
	wire logic [31:0] st_word = {27'h0, twi_nack_q, twi_done_q, spi_done_q,
		twi_busy, spi_busy};
	wire logic [31:0] fru_word = {7'h0, fru_sum_q == 8'h00,
		bmspi_pkg::tl_count(fru_last_q), bmspi_pkg::tl_is_ascii(fru_last_q),
		fru_last_q == bmspi_pkg::FRU_EOI, fru_last_q, fru_sum_q};
	// Length byte in eight-byte units, plus opening-byte checks
	wire logic [31:0] area_word = {19'h0,
		fru_last_q == bmspi_pkg::FRU_LANG_LATIN1,
		fru_last_q == bmspi_pkg::FRU_FMT_VER,
		{3'h0, fru_last_q} << bmspi_pkg::FRU_LEN_UNIT_SH};
	wire logic [31:0] rd_mux =
		(a_ofs == bmspi_pkg::REG_SPI_CMD) ? {18'h0, spi_nbits_q, 4'h0, SPI_SEL} :
		(a_ofs == bmspi_pkg::REG_SPI_TX) ? spi_tx_q :
		(a_ofs == bmspi_pkg::REG_SPI_RX) ? spi_rx_q :
		(a_ofs == bmspi_pkg::REG_STATUS) ? st_word :
		(a_ofs == bmspi_pkg::REG_TWI_CMD) ? {30'h0, twi_tgt_q} :
		(a_ofs == bmspi_pkg::REG_TWI_WDATA) ? {16'h0, twi_wd_q} :
		(a_ofs == bmspi_pkg::REG_TWI_RDATA) ? {16'h0, twi_rdata} :
		(a_ofs == bmspi_pkg::REG_FRU) ? fru_word :
		(a_ofs == bmspi_pkg::REG_FRU_AREA) ? area_word : 32'h00000000;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			HRDATA <= bmspi_pkg::RST_WORD;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			wr_pend_q <= acc && HWRITE;
			wr_addr_q <= a_ofs;
			if (acc && !HWRITE) begin
				HRDATA <= rd_mux;
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			spi_tx_q <= bmspi_pkg::RST_WORD;
			twi_wd_q <= 16'h0000;
		end else begin
			if (wr_tx) begin
				spi_tx_q <= HWDATA;
			end
			if (wr_twd) begin
				twi_wd_q <= HWDATA[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial chain master
	bmspi_pkg::bmspi_sp_t sp_q;
	logic [15:0] half_q;
	logic [5:0] left_q;
	logic [31:0] txsh_q;
	logic [31:0] rxsh_q;
	wire logic half_end = half_q == 16'(SCLK_HALF - 1);
	// Codes 4..7 address nothing and are refused
	wire logic sel_ok = HWDATA[bmspi_pkg::SEL_IO_BIT]
		|| !HWDATA[bmspi_pkg::SEL_BAD_BIT];
	wire logic [5:0] req_bits = HWDATA[13:8];
	wire logic spi_go = wr_cmd && !spi_busy && sel_ok && req_bits != 6'h00
		&& !(HWDATA[13] && req_bits[4:0] != 5'h00);
	wire logic spi_end = sp_q == bmspi_pkg::SP_END && half_end;
	assign spi_busy = sp_q != bmspi_pkg::SP_IDLE;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			half_q <= 16'h0000;
		end else begin
			half_q <= (!spi_busy || half_end) ? 16'h0000 : half_q + 16'h0001;
		end
	end

	// Select held for the whole frame; one bit per serial clock
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sp_q <= bmspi_pkg::SP_IDLE;
			SPI_SCLK <= 1'b0;
			SPI_CS_N <= 1'b1;
			SPI_SEL <= bmspi_pkg::RST_SEL;
			SPI_MOSI <= 1'b0;
			left_q <= 6'h00;
			spi_nbits_q <= 6'h00;
			txsh_q <= 32'h00000000;
			rxsh_q <= 32'h00000000;
			spi_rx_q <= 32'h00000000;
		end else begin
			unique case (sp_q)
			bmspi_pkg::SP_IDLE: begin
				if (spi_go) begin
					sp_q <= bmspi_pkg::SP_LOW;
					SPI_CS_N <= 1'b0;
					SPI_SEL <= HWDATA[3:0];
					SPI_MOSI <= spi_tx_q[0];
					txsh_q <= spi_tx_q >> 1;
					left_q <= req_bits;
					spi_nbits_q <= req_bits;
				end
			end
			bmspi_pkg::SP_LOW: begin
				if (half_end) begin
					sp_q <= bmspi_pkg::SP_HIGH;
					SPI_SCLK <= 1'b1;
				end
			end
			bmspi_pkg::SP_HIGH: begin
				if (half_end) begin
					SPI_SCLK <= 1'b0;
					rxsh_q <= {miso_s, rxsh_q[31:1]};
					left_q <= left_q - 6'h01;
					SPI_MOSI <= txsh_q[0];
					txsh_q <= txsh_q >> 1;
					sp_q <= (left_q == 6'h01) ? bmspi_pkg::SP_END
						: bmspi_pkg::SP_LOW;
				end
			end
			bmspi_pkg::SP_END: begin
				if (half_end) begin
					sp_q <= bmspi_pkg::SP_IDLE;
					SPI_CS_N <= 1'b1;
					spi_rx_q <= rxsh_q >> (6'd32 - spi_nbits_q);
				end
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Two-wire master
	wire logic twi_fin;
	wire logic rbv;
	wire logic [7:0] rbyte;
	wire logic twi_nack;
	wire logic [1:0] tgt = HWDATA[1:0];
	wire logic [7:0] tgt_addr = (tgt == bmspi_pkg::TGT_SENSOR)
		? bmspi_pkg::TWI_SENSOR_ADDR : (tgt == bmspi_pkg::TGT_FILT1)
		? bmspi_pkg::TWI_FILT1_ADDR : bmspi_pkg::TWI_FILT2_ADDR;
	// Target 3 is refused; commands such as AAh/EEh/17h come in the data
	wire logic twi_go = wr_tcmd && !twi_busy && tgt != 2'h3;
	wire logic fru_byte = rbv && twi_tgt_q != bmspi_pkg::TGT_SENSOR;

	bmspi_twi #(.QTR(TWI_QTR)) u_twi (
		.clk(REF_CLK),
		.rst(RST),
		.start(twi_go),
		.addr(tgt_addr),
		.wbytes(twi_wd_q),
		.nwr(HWDATA[9:8]),
		.nrd(HWDATA[11:10]),
		.sda_in(sda_s),
		.scl_in(scl_s),
		.busy(twi_busy),
		.done(twi_fin),
		.nack(twi_nack),
		.rdata(twi_rdata),
		.rbyte_valid(rbv),
		.rbyte(rbyte),
		.scl_oe(TWI_SCL_OE),
		.sda_oe(TWI_SDA_OE)
	);
	// Open drain: only ever pulled low
	assign TWI_SCL_O = 1'b0;
	assign TWI_SDA_O = 1'b0;

	// Sticky flags; a new event beats a write-one clear
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			spi_done_q <= 1'b0;
			twi_done_q <= 1'b0;
			twi_nack_q <= 1'b0;
			twi_tgt_q <= 2'h0;
		end else begin
			spi_done_q <= spi_end || (spi_done_q && !(wr_st && HWDATA[2]));
			twi_done_q <= twi_fin || (twi_done_q && !(wr_st && HWDATA[3]));
			twi_nack_q <= (twi_fin && twi_nack)
				|| (twi_nack_q && !(wr_st && HWDATA[4]));
			if (twi_go) begin
				twi_tgt_q <= tgt;
			end
		end
	end

	// Running sum over inventory bytes; zero over a whole area is valid
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			fru_sum_q <= 8'h00;
			fru_last_q <= 8'h00;
		end else begin
			if (fru_byte) begin
				fru_sum_q <= (wr_fru ? 8'h00 : fru_sum_q) + rbyte;
				fru_last_q <= rbyte;
			end else if (wr_fru) begin
				fru_sum_q <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	logic [5:0] edges_q;
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			edges_q <= 6'h00;
		end else if (sp_q == bmspi_pkg::SP_IDLE) begin
			edges_q <= 6'h00;
		end else if (sp_q == bmspi_pkg::SP_LOW && half_end) begin
			edges_q <= edges_q + 6'h01;
		end
	end

	// High time counted, so any SCLK_HALF is checked
	logic [15:0] hi_q;
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			hi_q <= 16'h0000;
		end else begin
			hi_q <= SPI_SCLK ? hi_q + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	a_sel_stable: assert property (!SPI_CS_N && $past(!SPI_CS_N) |->
		$stable(SPI_SEL)) else $error("select moved inside a frame");
	a_sel_code: assert property ($fell(SPI_CS_N) |->
		SPI_SEL[3] || !SPI_SEL[2]) else $error("undefined select code");
	a_bit_count: assert property ($rose(SPI_CS_N) |->
		edges_q == spi_nbits_q) else $error("clock count differs");
	a_sclk_half: assert property ($fell(SPI_SCLK) |->
		hi_q == 16'(SCLK_HALF)) else $error("serial clock high time");
	a_sclk_idle: assert property (SPI_CS_N |-> !SPI_SCLK)
		else $error("serial clock runs while deselected");
	a_spi_done: assert property ($rose(SPI_CS_N) |-> spi_done_q)
		else $error("done flag missing");
	a_twi_addr: assert property (twi_go |->
		tgt_addr inside {8'h98, 8'hA0, 8'hA2}) else $error("bad address");
	a_fru_sum: assert property (fru_byte && !wr_fru |=>
		fru_sum_q == 8'($past(fru_sum_q) + $past(rbyte)))
		else $error("checksum not accumulated");
	a_eoi_flag: assert property (fru_byte && rbyte == 8'hC1 |=>
		fru_word[16]) else $error("end marker missed");
	a_tl_count: assert property (fru_byte |=>
		fru_word[23:18] == $past(rbyte[5:0])) else $error("length field");

	c_spi_frame: cover property ($rose(SPI_CS_N) && spi_nbits_q == 6'd32);
	c_twi_done: cover property (twi_fin && !twi_nack);
	c_twi_nack: cover property (twi_fin && twi_nack);
	c_fru_eoi: cover property (fru_byte && rbyte == 8'hC1);
endmodule : bmspi_top

//--- bmspi_dev.sv
`timescale 1ns/1ps
module bmspi_dev #(
	parameter logic [31:0] ADC_WORD = 32'h0000C35A,
	parameter logic [7:0] MY_ADDR = bmspi_pkg::TWI_SENSOR_ADDR
) (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] sel,
	input wire logic mosi,
	output logic miso,
	input wire logic strap,
	input wire logic [7:0] ovh_n,
	input wire logic [7:0] flt_n,
	input wire logic [3:0] ratio,
	input wire logic [1:0] mem_n,
	input wire logic [7:0] slot,
	input wire logic [3:0] vid_n,
	output logic [7:0] cpu_disable_out,
	output logic [6:0] cfg,
	input wire logic scl,
	input wire logic sda,
	output logic ack_oe = 1'b0,
	output logic [7:0] twi_addr = 8'h00,
	output logic [7:0] twi_last = 8'h00
);
	logic [31:0] sh = 32'h0;
	logic [31:0] stat;
	logic [15:0] in_q = 16'h0;
	logic [15:0] ctrl_q = 16'h0;
	logic [7:0] tsh = 8'h0;
	logic [3:0] cnt = 4'h0;
	logic first = 1'b0;
	logic match = 1'b0;

	////////////////////////////////////////
	assign stat = {slot, flt_n[7], ovh_n[7], flt_n[6], ovh_n[6],
		flt_n[5], ovh_n[5], flt_n[4], ovh_n[4], 2'h3, mem_n[0],
		mem_n[1], flt_n[3], ovh_n[3], flt_n[2], ovh_n[2],
		ratio[0], ratio[1], ratio[2], ratio[3],
		flt_n[1], ovh_n[1], flt_n[0], ovh_n[0]};
	// Late by 1 ns: select settles on the same edge as the frame start
	always @(negedge cs_n) begin
		#1;
		case (sel)
		bmspi_pkg::SEL_STAT: sh = stat;
		bmspi_pkg::SEL_CONFL: sh = {21'h0, cfg, vid_n};
		bmspi_pkg::SEL_ADC: sh = ADC_WORD;
		default: sh = sh;
		endcase
	end
	always @(negedge sclk) if (!cs_n) sh = sh >> 1;
	always @(posedge sclk) if (!cs_n) in_q = {mosi, in_q[15:1]};
	always @(posedge cs_n) if (sel == bmspi_pkg::SEL_CTRL) ctrl_q = in_q;
	// Unselected line shows the inverse, never a stale bit
	assign miso = (!cs_n && !sel[3]) ? sh[0] : ~sh[0];
	assign cfg = ctrl_q[15] ? ctrl_q[14:8] : 7'h00;
	assign cpu_disable_out = strap ? 8'h00 : ctrl_q[7:0];

	////////////////////////////////////////
	always @(negedge sda) if (scl) begin
		cnt = 4'h0;
		first = 1'b1;
	end
	always @(posedge sda) if (scl) match = 1'b0;
	always @(posedge scl) begin
		if (cnt < 4'h8) tsh = {tsh[6:0], sda};
		if (cnt == 4'h7 && first) begin
			twi_addr = tsh;
			match = (tsh[7:1] == MY_ADDR[7:1]);
		end else if (cnt == 4'h7) twi_last = tsh;
		if (cnt == 4'h7) first = 1'b0;
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end
	always @(negedge scl) ack_oe = match && (cnt == 4'h8);
endmodule : bmspi_dev

//--- bmspi_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) chk(n, e, s)
module bmspi_top_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rx;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic [3:0] sel;
	logic scl_oe;
	logic sda_oe;
	logic ack_oe;
	logic strap = 1'b0;
	logic [7:0] ovh_n = 8'hFF;
	logic [7:0] flt_n = 8'hFF;
	logic [7:0] slot = 8'h00;
	logic [7:0] dis;
	logic [7:0] taddr;
	logic [7:0] tlast;
	logic [6:0] cfg;
	logic [3:0] ratio = 4'h0;
	logic [3:0] vid_n = 4'h6;
	logic [1:0] mem_n = 2'h3;
	logic [15:0] ctab [3] = '{16'hEBA5, 16'h7F3C, 16'hC15A};
	logic [7:0] edis [3] = '{8'hA5, 8'h3C, 8'h00};
	logic [6:0] ecfg [3] = '{7'h6B, 7'h00, 7'h41};
	logic [7:0] cmds [5] = '{8'hAA, 8'hEE, 8'h22, 8'h17, 8'hAC};
	wire scl = ~scl_oe;
	wire sda = ~(sda_oe | ack_oe);
	int bad_count = 0;
	int n_tests = 0;

	always #50 ref_clk = ~ref_clk;

	bmspi_top #(.SCLK_HALF(3), .TWI_QTR(2)) bmspi_top_i (.REF_CLK(ref_clk),
		.RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .SPI_SCLK(sclk),
		.SPI_CS_N(cs_n), .SPI_SEL(sel), .SPI_MOSI(mosi), .SPI_MISO(miso),
		.TWI_SCL_I(scl), .TWI_SCL_O(), .TWI_SCL_OE(scl_oe),
		.TWI_SDA_I(sda), .TWI_SDA_O(), .TWI_SDA_OE(sda_oe));
	bmspi_dev bmspi_dev_i (.sclk(sclk), .cs_n(cs_n), .sel(sel), .mosi(mosi),
		.miso(miso), .strap(strap), .ovh_n(ovh_n), .flt_n(flt_n),
		.ratio(ratio), .mem_n(mem_n), .slot(slot), .vid_n(vid_n),
		.cpu_disable_out(dis), .cfg(cfg), .scl(scl), .sda(sda),
		.ack_oe(ack_oe), .twi_addr(taddr), .twi_last(tlast));

	////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rx = hrdata;
	endtask : ahb
	// First poll already sees the busy flag; still at least two polls
	task idle;
		int i;
		i = 0;
		do begin
			ahb(1'b0, bmspi_pkg::REG_STATUS, 32'h0);
			i++;
		end while ((rx[1:0] !== 2'h0 || i < 2) && i < 400);
		`CHK("idle", 32'h0, i / 400);
	endtask : idle
	task frame(input logic [3:0] s, input logic [5:0] n, input logic [31:0] t);
		ahb(1'b1, bmspi_pkg::REG_SPI_TX, t);
		ahb(1'b1, bmspi_pkg::REG_SPI_CMD, {18'h0, n, 4'h0, s});
		idle();
		ahb(1'b0, bmspi_pkg::REG_SPI_RX, 32'h0);
	endtask : frame
	task twi(input logic [1:0] t, input logic [7:0] c);
		ahb(1'b1, bmspi_pkg::REG_STATUS, 32'h1C);
		ahb(1'b1, bmspi_pkg::REG_TWI_WDATA, {24'h0, c});
		ahb(1'b1, bmspi_pkg::REG_TWI_CMD, {22'h0, 2'h1, 6'h0, t});
		idle();
		ahb(1'b0, bmspi_pkg::REG_STATUS, 32'h0);
	endtask : twi
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	////////////////////////////////////////
	initial begin
		#4000000;
		bad_count++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		ahb(1'b0, bmspi_pkg::REG_STATUS, 32'h0);
		`CHK("status", 32'h0, rx);
		ahb(1'b1, 8'h40, 32'hFFFFFFFF);
		ahb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rx);
		`CHK("cs idle", 32'h1, cs_n);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			strap <= (i == 2);
			frame(bmspi_pkg::SEL_CTRL, 6'd16, {16'h0, ctab[i]});
			`CHK("disable", edis[i], dis);
			`CHK("cfg", ecfg[i], cfg);
			frame(bmspi_pkg::SEL_CONFL, 6'd11, 32'h0);
			`CHK("readback", {21'h0, ecfg[i], vid_n}, rx);
		end
		strap <= 1'b0;
		frame(4'h9, 6'd16, 32'hFFFF);
		`CHK("other board", 8'h5A, dis);
		`CHK("other cfg", 7'h41, cfg);
		$display("test control done");
		ahb(1'b1, bmspi_pkg::REG_SPI_CMD, 32'h0001);
		ahb(1'b1, bmspi_pkg::REG_SPI_CMD, 32'h0805);
		ahb(1'b0, bmspi_pkg::REG_STATUS, 32'h0);
		ahb(1'b0, bmspi_pkg::REG_SPI_CMD, 32'h0);
		`CHK("refused", 32'h1009, rx);
		ovh_n <= 8'hFE;
		flt_n <= 8'h7F;
		ratio <= 4'hC;
		mem_n <= 2'h2;
		slot <= 8'h0F;
		ahb(1'b1, bmspi_pkg::REG_SPI_CMD, {18'h0, 6'd32, 4'h0, 4'h0});
		@(posedge ref_clk);
		// Changed mid-frame: must not reach the captured word
		slot <= 8'h00;
		idle();
		ahb(1'b0, bmspi_pkg::REG_SPI_RX, 32'h0);
		`CHK("status chain", 32'h0F7FDF3E, rx);
		ahb(1'b0, bmspi_pkg::REG_STATUS, 32'h0);
		`CHK("done", 1'b1, rx[2]);
		ahb(1'b1, bmspi_pkg::REG_STATUS, 32'h4);
		ahb(1'b0, bmspi_pkg::REG_STATUS, 32'h0);
		ahb(1'b0, bmspi_pkg::REG_STATUS, 32'h0);
		`CHK("done clr", 1'b0, rx[2]);
		frame(bmspi_pkg::SEL_ADC, 6'd16, 32'h0);
		`CHK("adc", 32'h0000C35A, rx);
		$display("test status done");
		for (int i = 0; i < 5; i++) begin
			twi(bmspi_pkg::TGT_SENSOR, cmds[i]);
			`CHK("sensor addr", bmspi_pkg::TWI_SENSOR_ADDR, taddr);
			`CHK("command", cmds[i], tlast);
			`CHK("ack", 1'b0, rx[4]);
		end
		ahb(1'b1, bmspi_pkg::REG_TWI_WDATA, {24'h0, bmspi_pkg::CMD_READ_TEMP});
		ahb(1'b1, bmspi_pkg::REG_TWI_CMD, 32'h00000900);
		idle();
		`CHK("read addr", bmspi_pkg::TWI_SENSOR_ADDR | 8'h01, taddr);
		ahb(1'b0, bmspi_pkg::REG_TWI_RDATA, 32'h0);
		`CHK("temp bytes", 32'h0000FFFF, rx);
		twi(bmspi_pkg::TGT_FILT1, 8'h00);
		`CHK("filt1 addr", bmspi_pkg::TWI_FILT1_ADDR, taddr);
		`CHK("filt1 nack", 1'b1, rx[4]);
		twi(bmspi_pkg::TGT_FILT2, 8'h00);
		`CHK("filt2 addr", bmspi_pkg::TWI_FILT2_ADDR, taddr);
		`CHK("filt2 nack", 1'b1, rx[4]);
		$display("test twi done");
		final_report();
	end
endmodule : bmspi_top_tb
